// ### pps_consts.svh
// pulse program sequencer constants: offsets, field positions, opcodes, timing counts
// assumes inclusion by name from the package and design files
`ifndef PPS_CONSTS_SVH
`define PPS_CONSTS_SVH

// ==========================================
// instruction word layout
`define PPS_WORD_W 80
`define PPS_OUT_HI 79
`define PPS_OUT_LO 56
`define PPS_ARG_HI 55
`define PPS_ARG_LO 36
`define PPS_OP_HI 35
`define PPS_OP_LO 32
`define PPS_DLY_HI 31
`define PPS_DLY_LO 0
`define PPS_FLAG_N 12
`define PPS_SHORT_HI 23
`define PPS_SHORT_LO 21

// ==========================================
// program memory and opcodes
`define PPS_DEPTH 4096
`define PPS_PC_W 12
`define PPS_OP_ADVANCE 4'h0
`define PPS_OP_HALT 4'h1
`define PPS_OP_LOOP_START 4'h2
`define PPS_OP_LOOP_END 4'h3
`define PPS_OP_JUMP 4'h6
`define PPS_OP_WAIT 4'h8

// ==========================================
// short-pulse codes
`define PPS_SHORT_OFF 3'h0
`define PPS_SHORT_MAX 3'h5
`define PPS_SHORT_ON 3'h7

// ==========================================
// timing
`define PPS_DLY_OVERHEAD 32'h00000003
`define PPS_DLY_MIN 32'h00000002
`define PPS_WAIT_EXTRA 32'h00000006

// ==========================================
// register map (word index = address)
`define PPS_REG_CTRL 4'h0
`define PPS_REG_STATUS 4'h1
`define PPS_REG_PC 4'h2
`define PPS_REG_LOAD_ADDR 4'h3
`define PPS_REG_LOAD_W0 4'h4
`define PPS_REG_LOAD_W1 4'h5
`define PPS_REG_LOAD_W2 4'h6
`define PPS_REG_FLAGS 4'h7
`define PPS_CTRL_START 0
`define PPS_CTRL_RESET 1
`define PPS_CTRL_TRIG 2

`endif

// ### pps_flag_monitor.sv
// flag connector model: counts high cycles on every flag output and the longest unbroken run on the lowest one
// assumes flags are registered on the rising edge of clock and clr is driven by the bench
`timescale 1ns/10ps
module pps_flag_monitor (
  input wire logic clock,
  input wire logic clr,
  input wire logic [11:0] flags,
  output logic [11:0][15:0] cnt,
  output int run0
);
  int cur0;
  // ==========================================
  // counters
  // non-blocking updates so the bench never races the counts at a clock edge
  always @(posedge clock) begin
    if (clr) begin
      cur0 <= 0;
      run0 <= 0;
      for (int i = 0; i < 12; i++) cnt[i] <= 16'h0;
    end else begin
      for (int i = 0; i < 12; i++) cnt[i] <= cnt[i] + ((flags[i] === 1'b1) ? 16'h1 : 16'h0);
      // a gap between instructions would split the run, so the longest run exposes it
      if (flags[0] === 1'b1) begin
        cur0 <= cur0 + 1;
        if (cur0 + 1 > run0) run0 <= cur0 + 1;
      end else begin
        cur0 <= 0;
      end
    end
  end
endmodule : pps_flag_monitor

// ### pps_pkg.sv
// pulse program sequencer package: execution states
// assumes pps_consts.svh is on the include path
`include "pps_consts.svh"
package pps_pkg;
  typedef enum logic [2:0] {
    PPS_IDLE,
    PPS_FETCH,
    PPS_DECODE,
    PPS_HOLD,
    PPS_WAIT_TRIG,
    PPS_WAIT_TAIL,
    PPS_STOPPED
  } pps_state_e;
endpackage : pps_pkg

// ### pps_sequencer.sv
// pulse program sequencer: program memory, fetch/decode, delay timing, flag outputs
// assumes a software master on the plain register port, synchronous trigger input
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "pps_consts.svh"
module pps_sequencer
  import pps_pkg::*;
#(
  parameter int DEPTH = `PPS_DEPTH,
  parameter int FLAGS = `PPS_FLAG_N
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic trigger,
  output logic [31:0] rdata_q,
  output logic [FLAGS-1:0] pulse_outputs_q,
  output logic running_q,
  output logic stopped_q,
  output logic waiting_q
);
  localparam int PCW = $clog2(DEPTH);

  // ==========================================
  // program memory
  logic [`PPS_WORD_W-1:0] prog_mem [DEPTH];
  logic [PCW-1:0] load_addr_q;
  logic [31:0] load_w0_q;
  logic [31:0] load_w1_q;
  logic [`PPS_WORD_W-1:0] word_q;
  logic [PCW-1:0] pc_q;

  // loader stages two low words then writing W2 commits the full word; all bits come from software
  always_ff @(posedge clock) begin
    if (wr_en && addr == `PPS_REG_LOAD_W2) begin
      prog_mem[load_addr_q] <= {wdata[15:0], load_w1_q, load_w0_q};
    end
    word_q <= prog_mem[pc_q];
  end

  // ==========================================
  // register writes
  logic start_req, reset_req, soft_trig;
  assign start_req = wr_en && addr == `PPS_REG_CTRL && wdata[`PPS_CTRL_START];
  assign reset_req = wr_en && addr == `PPS_REG_CTRL && wdata[`PPS_CTRL_RESET];
  assign soft_trig = wr_en && addr == `PPS_REG_CTRL && wdata[`PPS_CTRL_TRIG];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      load_addr_q <= '0;
      load_w0_q <= 32'h0;
      load_w1_q <= 32'h0;
    end else if (wr_en) begin
      if (addr == `PPS_REG_LOAD_ADDR) begin
        load_addr_q <= wdata[PCW-1:0];
      end else if (addr == `PPS_REG_LOAD_W0) begin
        load_w0_q <= wdata;
      end else if (addr == `PPS_REG_LOAD_W1) begin
        load_w1_q <= wdata;
      end else if (addr == `PPS_REG_LOAD_W2) begin
        load_addr_q <= load_addr_q + 1'b1;
      end
    end
  end

  // ==========================================
  // field split
  logic [23:0] f_out;
  logic [19:0] f_arg;
  logic [3:0] f_op;
  logic [31:0] f_dly;
  assign f_out = word_q[`PPS_OUT_HI:`PPS_OUT_LO];
  assign f_arg = word_q[`PPS_ARG_HI:`PPS_ARG_LO];
  assign f_op = word_q[`PPS_OP_HI:`PPS_OP_LO];
  assign f_dly = word_q[`PPS_DLY_HI:`PPS_DLY_LO];

  // ==========================================
  // execution engine
  pps_state_e state_q;
  logic [31:0] cnt_q;
  logic [19:0] loop_cnt_q;
  logic [PCW-1:0] next_pc_q;
  logic [3:0] op_q;
  logic inst_start;
  logic trig_seen;
  assign trig_seen = trigger || soft_trig;
  assign inst_start = (state_q == PPS_DECODE);

  // one fetch and one decode cycle plus (delay + overhead - 1) hold cycles; delay 2 gives six total
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PPS_IDLE;
      pc_q <= '0;
      cnt_q <= 32'h0;
      loop_cnt_q <= 20'h0;
      next_pc_q <= '0;
      op_q <= 4'h0;
    end else if (reset_req) begin
      state_q <= PPS_IDLE;
      pc_q <= '0;
    end else begin
      case (state_q)
        PPS_IDLE: begin
          if (start_req || trig_seen) begin
            pc_q <= '0;
            state_q <= PPS_FETCH;
          end
        end
        PPS_FETCH: begin
          state_q <= PPS_DECODE;
        end
        PPS_DECODE: begin
          op_q <= f_op;
          cnt_q <= f_dly + `PPS_DLY_OVERHEAD - 32'h00000002;
          next_pc_q <= pc_q + 1'b1;
          if (f_op == `PPS_OP_LOOP_START) begin
            loop_cnt_q <= f_arg;
          end else if (f_op == `PPS_OP_LOOP_END) begin
            if (loop_cnt_q > 20'h1) begin
              next_pc_q <= f_arg[PCW-1:0];
            end
            loop_cnt_q <= loop_cnt_q - 20'h1;
          end else if (f_op == `PPS_OP_JUMP) begin
            next_pc_q <= f_arg[PCW-1:0];
          end
          state_q <= (f_op == `PPS_OP_WAIT) ? PPS_WAIT_TRIG : PPS_HOLD;
        end
        PPS_HOLD: begin
          if (cnt_q == 32'h0) begin
            if (op_q == `PPS_OP_HALT) begin
              state_q <= PPS_STOPPED;
            end else begin
              pc_q <= next_pc_q;
              state_q <= PPS_FETCH;
            end
          end else begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        PPS_WAIT_TRIG: begin
          if (trig_seen) begin
            state_q <= PPS_WAIT_TAIL;
            // cnt_q holds delay+1 here; a delay+3 tail plus fetch, decode and gate puts flags delay+6 out
            cnt_q <= cnt_q + `PPS_WAIT_EXTRA - 32'h00000005;
          end
        end
        PPS_WAIT_TAIL: begin
          if (cnt_q == 32'h0) begin
            pc_q <= next_pc_q;
            state_q <= PPS_FETCH;
          end else begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        PPS_STOPPED: begin
          state_q <= PPS_STOPPED;
        end
        default: begin
          state_q <= PPS_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // flag outputs: pattern loaded at instruction start, short codes clear it after their count, so held bits never glitch
  logic [FLAGS-1:0] gated;

  pps_short_gate #(
    .FLAGS(FLAGS)
  ) u_gate (
    .clock(clock),
    .rst_n(rst_n),
    .start(inst_start),
    .code(f_out[`PPS_SHORT_HI:`PPS_SHORT_LO]),
    .pattern(f_out[FLAGS-1:0]),
    .flags_q(gated)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pulse_outputs_q <= '0;
    end else begin
      pulse_outputs_q <= gated;
    end
  end

  // ==========================================
  // status
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      running_q <= 1'b0;
      stopped_q <= 1'b0;
      waiting_q <= 1'b0;
    end else begin
      running_q <= !(state_q == PPS_IDLE || state_q == PPS_STOPPED);
      stopped_q <= (state_q == PPS_STOPPED);
      waiting_q <= (state_q == PPS_WAIT_TRIG);
    end
  end

  // ==========================================
  // register reads
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0;
    end else if (rd_en) begin
      if (addr == `PPS_REG_STATUS) begin
        rdata_q <= {29'h0, waiting_q, stopped_q, running_q};
      end else if (addr == `PPS_REG_PC) begin
        rdata_q <= 32'(pc_q);
      end else if (addr == `PPS_REG_LOAD_ADDR) begin
        rdata_q <= 32'(load_addr_q);
      end else if (addr == `PPS_REG_LOAD_W0) begin
        rdata_q <= load_w0_q;
      end else if (addr == `PPS_REG_LOAD_W1) begin
        rdata_q <= load_w1_q;
      end else if (addr == `PPS_REG_FLAGS) begin
        rdata_q <= 32'(pulse_outputs_q);
      end else begin
        rdata_q <= 32'h0;
      end
    end else begin
      rdata_q <= 32'h0;
    end
  end

  // ==========================================
  // checks
  property p_halt_stops;
    @(posedge clock) disable iff (!rst_n)
      (state_q == PPS_HOLD && cnt_q == 32'h0 && op_q == `PPS_OP_HALT && !reset_req) |=> (state_q == PPS_STOPPED);
  endproperty
  a_halt_stops: assert property (p_halt_stops) else $error("halt did not stop");

  property p_flags_off;
    @(posedge clock) disable iff (!rst_n)
      (inst_start && f_out[23:21] == 3'h0) |=> ##1 (pulse_outputs_q == '0);
  endproperty
  a_flags_off: assert property (p_flags_off) else $error("code 000 left flags on");

  property p_flags_full;
    @(posedge clock) disable iff (!rst_n)
      (inst_start && f_out[23:21] == 3'h7) |=> ##1 (pulse_outputs_q == $past(f_out[FLAGS-1:0], 2));
  endproperty
  a_flags_full: assert property (p_flags_full) else $error("flag pattern wrong");

  property p_short_one;
    @(posedge clock) disable iff (!rst_n)
      (inst_start && f_out[23:21] == 3'h1) |=> ##2 (pulse_outputs_q == '0);
  endproperty
  a_short_one: assert property (p_short_one) else $error("one-cycle pulse too long");

  property p_advance;
    @(posedge clock) disable iff (!rst_n)
      (state_q == PPS_DECODE && f_op == `PPS_OP_ADVANCE && !reset_req) |=> (next_pc_q == $past(pc_q) + 1'b1);
  endproperty
  a_advance: assert property (p_advance) else $error("advance target wrong");

  property p_jump;
    @(posedge clock) disable iff (!rst_n)
      (state_q == PPS_DECODE && f_op == `PPS_OP_JUMP && !reset_req) |=> (next_pc_q == $past(f_arg[PCW-1:0]));
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");

  property p_loop_load;
    @(posedge clock) disable iff (!rst_n)
      (state_q == PPS_DECODE && f_op == `PPS_OP_LOOP_START && !reset_req) |=> (loop_cnt_q == $past(f_arg));
  endproperty
  a_loop_load: assert property (p_loop_load) else $error("loop count not loaded");

  property p_min_len;
    @(posedge clock) disable iff (!rst_n)
      (state_q == PPS_DECODE && f_dly == 32'h2 && f_op == 4'h0 && !reset_req) |=> (state_q == PPS_HOLD) [*4];
  endproperty
  a_min_len: assert property (p_min_len) else $error("short instruction timing");

  property p_wait_tail;
    @(posedge clock) disable iff (!rst_n)
      (state_q == PPS_WAIT_TRIG && trig_seen && f_dly == `PPS_DLY_MIN && !reset_req) |=> ##5 (state_q == PPS_FETCH);
  endproperty
  a_wait_tail: assert property (p_wait_tail) else $error("wait latency wrong");
endmodule : pps_sequencer

// ### pps_short_gate.sv
// short-pulse gate: masks the flag pattern after a programmed number of cycles
// assumes start pulses on the first cycle of each instruction
`timescale 1ns/10ps
`include "pps_consts.svh"
module pps_short_gate #(
  parameter int FLAGS = 12
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [2:0] code,
  input wire logic [FLAGS-1:0] pattern,
  output logic [FLAGS-1:0] flags_q
);
  logic [2:0] code_q;
  logic [2:0] cnt_q;
  logic [FLAGS-1:0] pat_q;
  logic on_d;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= 3'h0;
      pat_q <= '0;
      cnt_q <= 3'h0;
    end else if (start) begin
      code_q <= code;
      pat_q <= pattern;
      cnt_q <= 3'h1;
    end else if (cnt_q != 3'h7) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // 000 keeps outputs low, 111 is unlimited, 001..101 count cycles; 110 treated as unlimited
  always_comb begin
    if (start) begin
      on_d = (code == `PPS_SHORT_OFF) ? 1'b0 : 1'b1;
    end else if (code_q == `PPS_SHORT_OFF) begin
      on_d = 1'b0;
    end else if (code_q <= `PPS_SHORT_MAX) begin
      on_d = (cnt_q < code_q);
    end else begin
      on_d = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= on_d ? (start ? pattern : pat_q) : '0;
    end
  end
endmodule : pps_short_gate

// ### tb_pulse_program_sequencer.sv
// self-checking bench for the pulse program sequencer
// assumes pps_consts.svh on the include path and the flag monitor compiled before this file
`timescale 1ns/10ps
`include "pps_consts.svh"
module tb_pulse_program_sequencer;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic trigger = 1'b0;
  logic clr = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata_q;
  logic [11:0] pulse_outputs_q;
  logic running_q;
  logic stopped_q;
  logic waiting_q;
  logic [31:0] rv;
  int lat;
  logic [11:0][15:0] cnt;
  int run0;
  int failures = 0;
  int checks = 0;

  always #2.5 clock = ~clock;

  pps_sequencer u_pps_sequencer (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .trigger(trigger), .rdata_q(rdata_q), .pulse_outputs_q(pulse_outputs_q),
    .running_q(running_q), .stopped_q(stopped_q), .waiting_q(waiting_q));
  pps_flag_monitor u_pps_flag_monitor (.clock(clock), .clr(clr), .flags(pulse_outputs_q), .cnt(cnt), .run0(run0));

  // ==========================================
  // helpers
  task conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 rv = rdata_q;
  endtask : rd

  function automatic logic [79:0] mk(input logic [23:0] o, input logic [3:0] op, input logic [31:0] d,
    input logic [19:0] arg);
    return {o, arg, op, d};
  endfunction : mk

  // every field is written, so no word is left partly undefined
  task put(input logic [11:0] a, input logic [79:0] w);
    wr(`PPS_REG_LOAD_ADDR, {20'h0, a});
    wr(`PPS_REG_LOAD_W0, w[31:0]);
    wr(`PPS_REG_LOAD_W1, w[63:32]);
    wr(`PPS_REG_LOAD_W2, {16'h0, w[79:64]});
  endtask : put

  task go;
    wr(`PPS_REG_CTRL, 32'h2);
    clr <= 1'b1;
    wr(`PPS_REG_CTRL, 32'h1);
    clr <= 1'b0;
  endtask : go

  task wait_stop;
    for (int i = 0; i < 2000 && stopped_q !== 1'b1; i++) @(posedge clock);
    chk(stopped_q, 1'b1, "not stopped");
  endtask : wait_stop

  // ==========================================
  // scenarios
  task t_reset;
    chk({pulse_outputs_q, running_q, stopped_q, waiting_q}, 15'h0, "reset outputs");
    rd(`PPS_REG_STATUS);
    chk(rv, 32'h0, "status after reset");
    rd(4'h8);
    chk(rv, 32'h0, "unmapped read");
    rd(`PPS_REG_LOAD_W2);
    chk(rv, 32'h0, "upper load word read");
  endtask : t_reset

  task t_prog;
    put(0, mk(24'he00821, `PPS_OP_ADVANCE, 32'h2, 20'h0));
    put(1, mk(24'hfff801, `PPS_OP_ADVANCE, 32'h6, 20'hfffff));
    put(2, mk(24'h600fff, `PPS_OP_ADVANCE, 32'ha, 20'h0));
    put(3, mk(24'h000fff, `PPS_OP_ADVANCE, 32'h2, 20'h0));
    put(4, mk(24'he00000, `PPS_OP_ADVANCE, 32'h3, 20'h0));
    put(5, mk(24'h000000, `PPS_OP_HALT, 32'h2, 20'h0));
    go();
    wait_stop();
    chk(cnt[0], 19, "lowest flag cycles");
    chk(run0, 19, "lowest flag gap");
    chk(cnt[5], 9, "six cycle word");
    chk(cnt[11], 19, "highest flag cycles");
    chk(cnt[3], 3, "three cycle pulse");
    chk(cnt[7], 3, "zero code keeps low");
    chk(pulse_outputs_q, 12'h0, "flags after halt");
    rd(`PPS_REG_PC);
    chk(rv, 32'h5, "pc held at halt");
    rd(`PPS_REG_LOAD_ADDR);
    chk(rv, 32'h6, "load address after six words");
    rd(`PPS_REG_LOAD_W0);
    chk(rv, 32'h2, "staged low word");
    rd(`PPS_REG_LOAD_W1);
    chk(rv, 32'h1, "staged middle word");
    rd(`PPS_REG_FLAGS);
    chk(rv, 32'h0, "flags register after halt");
    rd(`PPS_REG_STATUS);
    chk(rv, 32'h2, "status stopped");
    wr(`PPS_REG_CTRL, 32'h1);
    repeat (20) @(posedge clock);
    chk({running_q, stopped_q}, 2'b01, "start in stopped");
  endtask : t_prog

  task t_codes;
    for (int c = 0; c < 8; c++) begin
      put(0, mk({c[2:0], 9'h0, 12'hfff}, `PPS_OP_ADVANCE, 32'ha, 20'h0));
      put(1, mk(24'he00000, `PPS_OP_ADVANCE, 32'h3, 20'h0));
      put(2, mk(24'h000000, `PPS_OP_HALT, 32'h2, 20'h0));
      go();
      wait_stop();
      chk(cnt[7], (c == 0) ? 0 : (c <= 5) ? c : 14, "short code");
    end
  endtask : t_codes

  task t_loop;
    put(0, mk(24'he00000, `PPS_OP_LOOP_START, 32'h2, 20'h3));
    put(1, mk(24'h200001, `PPS_OP_ADVANCE, 32'h2, 20'h0));
    put(2, mk(24'he00000, `PPS_OP_LOOP_END, 32'h2, 20'h1));
    put(3, mk(24'h200800, `PPS_OP_JUMP, 32'h2, 20'h5));
    put(4, mk(24'he00fff, `PPS_OP_ADVANCE, 32'h2, 20'h0));
    put(5, mk(24'he00000, `PPS_OP_ADVANCE, 32'h3, 20'h0));
    put(6, mk(24'h000000, `PPS_OP_HALT, 32'h2, 20'h0));
    go();
    wait_stop();
    chk(cnt[0], 3, "loop body passes");
    chk(cnt[11], 1, "jump word");
    chk(cnt[4], 0, "skipped word");
  endtask : t_loop

  task t_wait;
    put(0, mk(24'he00000, `PPS_OP_ADVANCE, 32'h2, 20'h0));
    put(1, mk(24'he00000, `PPS_OP_WAIT, 32'h2, 20'h0));
    put(2, mk(24'he00002, `PPS_OP_ADVANCE, 32'h2, 20'h0));
    put(3, mk(24'he00000, `PPS_OP_ADVANCE, 32'h3, 20'h0));
    put(4, mk(24'h000000, `PPS_OP_HALT, 32'h2, 20'h0));
    go();
    for (int i = 0; i < 200 && waiting_q !== 1'b1; i++) @(posedge clock);
    repeat (30) @(posedge clock);
    chk({waiting_q, stopped_q}, 2'b10, "holds in wait");
    chk(cnt[1], 0, "no advance before trigger");
    rd(`PPS_REG_STATUS);
    chk(rv, 32'h5, "status waiting");
    @(posedge clock);
    trigger <= 1'b1;
    @(posedge clock);
    trigger <= 1'b0;
    // flags move delay+6 edges after the trigger edge; the bench sees each edge's update one edge later
    for (lat = 0; lat < 50 && pulse_outputs_q[1] !== 1'b1; lat++) @(posedge clock);
    chk(lat, `PPS_DLY_MIN + `PPS_WAIT_EXTRA + 32'h1, "wait latency");
    wait_stop();
    chk(cnt[1], 6, "word after trigger");
    chk(waiting_q, 1'b0, "wait left");
  endtask : t_wait

  // ==========================================
  // main sequence and watchdog
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_prog();
    t_codes();
    t_loop();
    t_wait();
    conclude();
  end

  // whole run is about a thousand cycles; this leaves a wide margin
  initial begin
    #200us;
    failures++;
    conclude();
  end
endmodule : tb_pulse_program_sequencer
